// ### bcr_map.vh
/*
  Address map, field positions, reset values and constants of the
  buck rail configuration register bank.
  Assumes inclusion by bcr_regs.v only; holds definitions alone.
*/
`ifndef BCR_MAP_VH
`define BCR_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BCR_IDX_AB_NORMAL   8'h20
`define BCR_IDX_AB_STANDBY  8'h21
`define BCR_IDX_AB_SLEEP    8'h22
`define BCR_IDX_AB_MODE     8'h23
`define BCR_IDX_AB_CONFIG   8'h24
`define BCR_IDX_C_NORMAL    8'h2e
`define BCR_IDX_C_STANDBY   8'h2f
`define BCR_IDX_C_SLEEP     8'h30
`define BCR_IDX_C_MODE      8'h31
`define BCR_IDX_C_CONFIG    8'h32

// ----------------------------------------------------------------
// Storage slots
// ----------------------------------------------------------------
`define BCR_NUM_SLOTS       10
`define BCR_SLOT_C_BASE     4'h5
`define BCR_SLOT_NORMAL     4'h0
`define BCR_SLOT_STANDBY    4'h1
`define BCR_SLOT_SLEEP      4'h2
`define BCR_SLOT_MODE       4'h3
`define BCR_SLOT_CONFIG     4'h4
`define BCR_SLOT_NONE       4'hf

// ----------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------
`define BCR_MASK_SETPOINT   8'h3f
`define BCR_MASK_MODE       8'h2f
`define BCR_MASK_CONFIG     8'hff
`define BCR_RESET_VALUE     8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BCR_VOLT_RANGE      5:0
`define BCR_MODE_RANGE      3:0
`define BCR_SLEEP_STATE_BIT 5
`define BCR_ILIM_BIT        0
`define BCR_FREQ_RANGE      3:2
`define BCR_PHASE_RANGE     5:4
`define BCR_SPEED_RANGE     7:6

// ----------------------------------------------------------------
// Set-point coding and power states
// ----------------------------------------------------------------
`define BCR_MV_BASE         11'h12c
`define BCR_MV_STEP         11'h019
`define BCR_PWR_NORMAL      2'h0
`define BCR_PWR_STANDBY     2'h1
`define BCR_PWR_SLEEP       2'h2

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define BCR_RESP_OKAY       2'h0
`define BCR_RESP_SLVERR     2'h2

`endif

// ### bcr_regs.v
/*
  Buck rail configuration register bank for the A/B pair and the C rail,
  reached over AXI4-Lite, with decoded controls for the converters.
  Assumes one 100 MHz clock, inputs synchronous to it, and a master that
  keeps at most one write and one read outstanding.
*/
// Function
// RULE_01: A/B normal set point, bits 5:0, reset zero
// RULE_02: A/B standby set point, bits 5:0, reset zero
// RULE_03: A/B sleep set point, bits 5:0, reset zero
// RULE_04: C normal set point, bits 5:0, reset zero
// RULE_05: C standby set point, bits 5:0, reset zero
// RULE_06: C sleep set point, bits 5:0, reset zero
// RULE_07: A/B switching mode selector in bits 3:0
// RULE_08: A/B bit 5 sleep state: off or pulse-frequency
// RULE_09: C switching mode selector in bits 3:0
// RULE_10: C bit 5 sleep state: off or pulse-frequency
// RULE_11: A/B current limit bit 0: high/low
// RULE_12: A/B frequency select bits 3:2
// RULE_13: A/B phase clock select bits 5:4
// RULE_14: A/B scaling speed select bits 7:6
// RULE_15: C current limit bit 0: high/low
// RULE_16: C frequency select bits 3:2
// RULE_17: C phase clock select bits 5:4
// RULE_18: C scaling speed select bits 7:6
// RULE_19: Set point: 300 mV plus 25 mV steps
// RULE_20: Dual phase drives both nodes from A/B config
// RULE_21: Unused bits read zero, writes ignored; config bit 1 is stored and reads back, since the config mask is 8'hff
`timescale 1ns/10ps
`include "bcr_map.vh"

module bcr_regs
(
   // Clock and reset
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   // AXI4-Lite write address
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire [2:0]  s_axi_awprot_i,
   // AXI4-Lite write data
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   // AXI4-Lite write response
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   output reg  [1:0]  s_axi_bresp_o,
   // AXI4-Lite read address
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire [2:0]  s_axi_arprot_i,
   // AXI4-Lite read data
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   // Power state and topology
   input  wire [1:0]  pwr_state_i,
   input  wire        dual_phase_i,
   // A/B pair controls
   output reg  [10:0] pair_ab_target_mv_o,
   output reg         pair_ab_enable_o,
   output reg  [3:0]  pair_ab_mode_select_o,
   output reg         pair_ab_current_limit_sel_o,
   output reg  [1:0]  pair_ab_phase_sel_o,
   // Switching nodes A and B
   output reg  [1:0]  node_a_frequency_sel_o,
   output reg  [1:0]  node_a_scaling_speed_o,
   output reg         node_b_enable_o,
   output reg  [1:0]  node_b_frequency_sel_o,
   output reg  [1:0]  node_b_scaling_speed_o,
   // C rail controls
   output reg  [10:0] rail_c_target_mv_o,
   output reg         rail_c_enable_o,
   output reg  [3:0]  rail_c_mode_select_o,
   output reg         rail_c_current_limit_sel_o,
   output reg  [1:0]  rail_c_frequency_sel_o,
   output reg  [1:0]  rail_c_phase_sel_o,
   output reg  [1:0]  rail_c_scaling_speed_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Byte address to storage slot; misaligned or unmapped gives none
   function [3:0] slot_of;
      input [7:0] addr;
      begin
         if (addr[1:0] != 2'h0)
            slot_of = `BCR_SLOT_NONE;
         else
         begin
            case ({2'h0, addr[7:2]})
               `BCR_IDX_AB_NORMAL:  slot_of = `BCR_SLOT_NORMAL;
               `BCR_IDX_AB_STANDBY: slot_of = `BCR_SLOT_STANDBY;
               `BCR_IDX_AB_SLEEP:   slot_of = `BCR_SLOT_SLEEP;
               `BCR_IDX_AB_MODE:    slot_of = `BCR_SLOT_MODE;
               `BCR_IDX_AB_CONFIG:  slot_of = `BCR_SLOT_CONFIG;
               `BCR_IDX_C_NORMAL:   slot_of = `BCR_SLOT_C_BASE + `BCR_SLOT_NORMAL;
               `BCR_IDX_C_STANDBY:  slot_of = `BCR_SLOT_C_BASE + `BCR_SLOT_STANDBY;
               `BCR_IDX_C_SLEEP:    slot_of = `BCR_SLOT_C_BASE + `BCR_SLOT_SLEEP;
               `BCR_IDX_C_MODE:     slot_of = `BCR_SLOT_C_BASE + `BCR_SLOT_MODE;
               `BCR_IDX_C_CONFIG:   slot_of = `BCR_SLOT_C_BASE + `BCR_SLOT_CONFIG;
               default:             slot_of = `BCR_SLOT_NONE;
            endcase
         end
      end
   endfunction

   // Implemented bits of a slot; the rest never store and read zero
   function [7:0] mask_of;
      input [3:0] slot;
      reg   [3:0] kind;
      begin
         kind = (slot >= `BCR_SLOT_C_BASE) ? slot - `BCR_SLOT_C_BASE : slot;
         case (kind)
            `BCR_SLOT_MODE:   mask_of = `BCR_MASK_MODE;
            `BCR_SLOT_CONFIG: mask_of = `BCR_MASK_CONFIG;
            default:          mask_of = `BCR_MASK_SETPOINT;
         endcase
      end
   endfunction

   // Set-point code to millivolts, linear from the base in fixed steps
   function [10:0] code_to_mv;
      input [5:0] code;
      begin
         code_to_mv = `BCR_MV_BASE + `BCR_MV_STEP * {5'h00, code}; // RULE_19
      end
   endfunction

   // Code active for the present power state
   function [5:0] active_code;
      input [1:0] state;
      input [7:0] normal;
      input [7:0] standby;
      input [7:0] sleep;
      begin
         case (state)
            `BCR_PWR_STANDBY: active_code = standby[`BCR_VOLT_RANGE];
            `BCR_PWR_SLEEP:   active_code = sleep[`BCR_VOLT_RANGE];
            default:          active_code = normal[`BCR_VOLT_RANGE];
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   reg rst_meta_n;
   reg rst_n;

   always @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   reg  [7:0] regs [0:`BCR_NUM_SLOTS-1];
   reg        aw_held;
   reg  [7:0] aw_addr;
   reg        w_held;
   reg  [7:0] w_data;
   reg        w_lane;

   // Address and data are taken in either order; both stall while a
   // response waits, so one write at most is ever in flight
   assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;

   wire       aw_fire  = s_axi_awvalid_i && s_axi_awready_o;
   wire       w_fire   = s_axi_wvalid_i && s_axi_wready_o;
   wire       do_write = (aw_held || aw_fire) && (w_held || w_fire);
   wire [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr_i;
   wire [7:0] wr_data  = w_held ? w_data : s_axi_wdata_i[7:0];
   wire       wr_lane  = w_held ? w_lane : s_axi_wstrb_i[0];
   wire [3:0] wr_slot  = slot_of(wr_addr);

   integer i;

   always @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_held        <= 1'b0;
         aw_addr        <= 8'h00;
         w_held         <= 1'b0;
         w_data         <= 8'h00;
         w_lane         <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `BCR_RESP_OKAY;
         for (i = 0; i < `BCR_NUM_SLOTS; i = i + 1)
            regs[i] <= `BCR_RESET_VALUE; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
      end
      else
      begin
         if (s_axi_bvalid_o && s_axi_bready_i)
            s_axi_bvalid_o <= 1'b0;
         if (do_write)
         begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            if (wr_slot == `BCR_SLOT_NONE)
               s_axi_bresp_o <= `BCR_RESP_SLVERR;
            else
            begin
               s_axi_bresp_o <= `BCR_RESP_OKAY;
               // Only byte lane 0 carries register bits
               if (wr_lane)
                  regs[wr_slot] <= wr_data & mask_of(wr_slot); // RULE_21
            end
         end
         else
         begin
            if (aw_fire)
            begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr_i;
            end
            if (w_fire)
            begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata_i[7:0];
               w_lane <= s_axi_wstrb_i[0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   wire [3:0] rd_slot = slot_of(s_axi_araddr_i);

   assign s_axi_arready_o = !s_axi_rvalid_o;

   always @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= `BCR_RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_rvalid_o <= 1'b1;
         if (rd_slot == `BCR_SLOT_NONE)
         begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `BCR_RESP_SLVERR;
         end
         else
         begin
            s_axi_rdata_o <= {24'h000000, regs[rd_slot] & mask_of(rd_slot)}; // RULE_21
            s_axi_rresp_o <= `BCR_RESP_OKAY;
         end
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
         s_axi_rvalid_o <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Converter controls
   // ----------------------------------------------------------------
   wire [7:0] ab_mode = regs[`BCR_SLOT_MODE];
   wire [7:0] ab_conf = regs[`BCR_SLOT_CONFIG];
   wire [7:0] c_mode  = regs[`BCR_SLOT_C_BASE + `BCR_SLOT_MODE];
   wire [7:0] c_conf  = regs[`BCR_SLOT_C_BASE + `BCR_SLOT_CONFIG];

   wire [5:0] ab_code = active_code(pwr_state_i,
                                    regs[`BCR_SLOT_NORMAL],
                                    regs[`BCR_SLOT_STANDBY],
                                    regs[`BCR_SLOT_SLEEP]);
   wire [5:0] c_code  = active_code(pwr_state_i,
                                    regs[`BCR_SLOT_C_BASE + `BCR_SLOT_NORMAL],
                                    regs[`BCR_SLOT_C_BASE + `BCR_SLOT_STANDBY],
                                    regs[`BCR_SLOT_C_BASE + `BCR_SLOT_SLEEP]);
   wire       in_sleep = (pwr_state_i == `BCR_PWR_SLEEP);

   // Registered once more so that outputs never glitch on a bus write
   always @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pair_ab_target_mv_o         <= `BCR_MV_BASE;
         pair_ab_enable_o            <= 1'b1;
         pair_ab_mode_select_o       <= 4'h0;
         pair_ab_current_limit_sel_o <= 1'b0;
         pair_ab_phase_sel_o         <= 2'h0;
         node_a_frequency_sel_o      <= 2'h0;
         node_a_scaling_speed_o      <= 2'h0;
         node_b_enable_o             <= 1'b0;
         node_b_frequency_sel_o      <= 2'h0;
         node_b_scaling_speed_o      <= 2'h0;
         rail_c_target_mv_o          <= `BCR_MV_BASE;
         rail_c_enable_o             <= 1'b1;
         rail_c_mode_select_o        <= 4'h0;
         rail_c_current_limit_sel_o  <= 1'b0;
         rail_c_frequency_sel_o      <= 2'h0;
         rail_c_phase_sel_o          <= 2'h0;
         rail_c_scaling_speed_o      <= 2'h0;
      end
      else
      begin
         pair_ab_target_mv_o <= code_to_mv(ab_code); // RULE_19
         rail_c_target_mv_o  <= code_to_mv(c_code); // RULE_19
         // In sleep a rail runs only if its sleep state picks pulse-frequency mode
         pair_ab_enable_o <= !in_sleep || ab_mode[`BCR_SLEEP_STATE_BIT]; // RULE_08
         rail_c_enable_o  <= !in_sleep || c_mode[`BCR_SLEEP_STATE_BIT]; // RULE_10
         pair_ab_mode_select_o       <= ab_mode[`BCR_MODE_RANGE]; // RULE_07
         rail_c_mode_select_o        <= c_mode[`BCR_MODE_RANGE]; // RULE_09
         pair_ab_current_limit_sel_o <= ab_conf[`BCR_ILIM_BIT]; // RULE_11
         rail_c_current_limit_sel_o  <= c_conf[`BCR_ILIM_BIT]; // RULE_15
         pair_ab_phase_sel_o         <= ab_conf[`BCR_PHASE_RANGE]; // RULE_13
         rail_c_phase_sel_o          <= c_conf[`BCR_PHASE_RANGE]; // RULE_17
         rail_c_frequency_sel_o      <= c_conf[`BCR_FREQ_RANGE]; // RULE_16
         rail_c_scaling_speed_o      <= c_conf[`BCR_SPEED_RANGE]; // RULE_18
         node_a_frequency_sel_o      <= ab_conf[`BCR_FREQ_RANGE]; // RULE_12
         node_a_scaling_speed_o      <= ab_conf[`BCR_SPEED_RANGE]; // RULE_14
         // Node B shares the pair's settings only when paired in phase
         node_b_enable_o <= dual_phase_i; // RULE_20
         if (dual_phase_i)
         begin
            node_b_frequency_sel_o <= ab_conf[`BCR_FREQ_RANGE]; // RULE_20
            node_b_scaling_speed_o <= ab_conf[`BCR_SPEED_RANGE]; // RULE_20
         end
         else
         begin
            node_b_frequency_sel_o <= 2'h0;
            node_b_scaling_speed_o <= 2'h0;
         end
      end
   end

endmodule

// ### bcr_regs_assertions.sv
/*
  Checker for the buck rail configuration bank: bus handshakes and
  the decoded converter controls seen at the ports.
  Assumes it is bound to bcr_regs and that there is one clock domain.
*/
`timescale 1ns/10ps

module bcr_regs_chk
(
   // Clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   // Register bus
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   // Power state and controls
   input wire logic [1:0]  pwr_state_i,
   input wire logic        dual_phase_i,
   input wire logic [10:0] pair_ab_target_mv_o,
   input wire logic        pair_ab_enable_o,
   input wire logic        rail_c_enable_o,
   input wire logic [1:0]  node_a_frequency_sel_o,
   input wire logic [1:0]  node_a_scaling_speed_o,
   input wire logic        node_b_enable_o,
   input wire logic [1:0]  node_b_frequency_sel_o,
   input wire logic [1:0]  node_b_scaling_speed_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   bresp_hold_a: assert property (
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response changed before it was accepted");
   rdata_hold_a: assert property (
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data changed before it was accepted");
   rdata_upper_zero_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
      else $error("read data has bits above the register width");
   read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer not given one cycle after address");
   write_answer_a: assert property (
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |=> s_axi_bvalid_o)
      else $error("write answer not given one cycle after transfer");
   target_range_a: assert property (pair_ab_target_mv_o >= 11'h12c &&
      pair_ab_target_mv_o <= 11'h753 && (pair_ab_target_mv_o - 11'h12c) % 11'h019 == 11'h0)
      else $error("pair target voltage off the set-point grid");
   sleep_off_a: assert property (
      !pair_ab_enable_o || !rail_c_enable_o |-> $past(pwr_state_i) == 2'h2)
      else $error("rail disabled outside sleep");
   node_b_follow_a: assert property (##1 node_b_enable_o == $past(dual_phase_i))
      else $error("second node enable does not follow dual phase");
   node_b_share_a: assert property (node_b_enable_o |->
      node_b_frequency_sel_o == node_a_frequency_sel_o &&
      node_b_scaling_speed_o == node_a_scaling_speed_o)
      else $error("second node settings differ from first node");
endmodule

bind bcr_regs bcr_regs_chk i_chk
(
   .core_clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
   .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i,
   .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .pwr_state_i,
   .dual_phase_i, .pair_ab_target_mv_o, .pair_ab_enable_o, .rail_c_enable_o,
   .node_a_frequency_sel_o, .node_a_scaling_speed_o, .node_b_enable_o,
   .node_b_frequency_sel_o, .node_b_scaling_speed_o
);

// ### bcr_regs_tb.sv
/*
  Self-checking bench for the buck rail configuration bank.
  Assumes bcr_regs answers each AXI4-Lite request one cycle after taking it.
*/
`timescale 1ns/10ps

module bcr_regs_tb;
   logic        clk, rst_n, awv, wv, bv, brdy, arv, rv, rrdy, dual;
   logic        awr, wr, arr;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd;
   logic [1:0]  br, rr, pwr;
   logic [10:0] ab_mv, c_mv;
   logic        ab_en, ab_il, nb_en, c_en, c_il;
   logic [3:0]  ab_md, c_md;
   logic [1:0]  ab_ph, na_f, na_s, nb_f, nb_s, c_f, c_ph, c_s;
   int          n_mismatch, cmp_count, cyc, i, p;
   logic [7:0]  adr [10] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90,
                              8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hc8};
   logic [7:0]  msk [10] = '{8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff,
                              8'h3f, 8'h3f, 8'h3f, 8'h2f, 8'hff};
   logic [7:0]  pat [3] = '{8'hff, 8'h55, 8'haa};
   logic [31:0] got;
   logic [1:0]  rsp;
   logic [3:0]  strb;

   bcr_regs i_dut
   (
      .core_clk_i(clk), .rst_n_i(rst_n),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
      .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(strb), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(brdy), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy), .s_axi_rdata_o(rd),
      .s_axi_rresp_o(rr), .pwr_state_i(pwr), .dual_phase_i(dual),
      .pair_ab_target_mv_o(ab_mv), .pair_ab_enable_o(ab_en),
      .pair_ab_mode_select_o(ab_md), .pair_ab_current_limit_sel_o(ab_il),
      .pair_ab_phase_sel_o(ab_ph), .node_a_frequency_sel_o(na_f),
      .node_a_scaling_speed_o(na_s), .node_b_enable_o(nb_en),
      .node_b_frequency_sel_o(nb_f), .node_b_scaling_speed_o(nb_s),
      .rail_c_target_mv_o(c_mv), .rail_c_enable_o(c_en), .rail_c_mode_select_o(c_md),
      .rail_c_current_limit_sel_o(c_il), .rail_c_frequency_sel_o(c_f),
      .rail_c_phase_sel_o(c_ph), .rail_c_scaling_speed_o(c_s)
   );

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] mv(input logic [7:0] code);
      mv = 32'd300 + 32'd25 * 32'(code[5:0]);
   endfunction

   // ----------------------------------------------------------------
   // Bus tasks: handshakes judged at the falling edge, where the
   // combinational readies have settled, and acted on at the next rise
   // ----------------------------------------------------------------
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ha, hw, hb, done;
      done = 1'b0;
      @(posedge clk);
      awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= {24'h0, d}; brdy <= 1'b1;
      while (!done)
      begin
         @(negedge clk);
         ha = awv && awr;
         hw = wv && wr;
         hb = bv && brdy;
         if (hb) check("bresp", 32'(er), 32'(br));
         @(posedge clk);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
         if (hb) brdy <= 1'b0;
         done = hb;
      end
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ha, hr, done;
      done = 1'b0;
      @(posedge clk);
      arv <= 1'b1; ara <= a; rrdy <= 1'b1;
      while (!done)
      begin
         @(negedge clk);
         ha = arv && arr;
         hr = rv && rrdy;
         if (hr) d = rd;
         if (hr) r = rr;
         @(posedge clk);
         if (ha) arv <= 1'b0;
         if (hr) rrdy <= 1'b0;
         done = hr;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      bus_rd(a, got, rsp);
      check("rdata", {24'h0, e}, got);
      check("rresp", 32'(er), 32'(rsp));
   endtask

   // Controls lag one edge behind a register or input change
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // Clock, reset, watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge clk);
         cyc++;
         if (cyc == 20000)
         begin
            n_mismatch++;
            tally_and_finish();
         end
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      n_mismatch = 0; cmp_count = 0; rst_n = 1'b0; awv = 1'b0; wv = 1'b0; brdy = 1'b0;
      arv = 1'b0; rrdy = 1'b0; awa = 8'h0; ara = 8'h0; wd = 32'h0; pwr = 2'h0; dual = 1'b0;
      strb = 4'hf;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check("ab_mv_reset", 32'd300, 32'(ab_mv));
      for (i = 0; i < 10; i++)
         rd_chk(adr[i], 8'h00, 2'h0);
      for (p = 0; p < 3; p++)
         for (i = 0; i < 10; i++)
         begin
            bus_wr(adr[i], pat[p], 2'h0);
            rd_chk(adr[i], pat[p] & msk[i], 2'h0);
         end
      bus_wr(8'h94, 8'h11, 2'h2);
      bus_wr(8'h81, 8'h11, 2'h2);
      rd_chk(8'h94, 8'h00, 2'h2);
      rd_chk(8'h80, 8'h2a, 2'h0);
      // Byte lane 0 off: the write is answered but changes nothing
      strb <= 4'he;
      bus_wr(8'h80, 8'h15, 2'h0);
      strb <= 4'hf;
      rd_chk(8'h80, 8'h2a, 2'h0);
      bus_wr(8'h80, 8'h3f, 2'h0);
      bus_wr(8'h84, 8'h0c, 2'h0);
      bus_wr(8'h88, 8'h20, 2'h0);
      bus_wr(8'hb8, 8'h01, 2'h0);
      bus_wr(8'hbc, 8'h3e, 2'h0);
      bus_wr(8'hc0, 8'h00, 2'h0);
      bus_wr(8'h8c, 8'h05, 2'h0);
      bus_wr(8'hc4, 8'h29, 2'h0);
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         pwr <= 2'(i);
         settle();
         check("ab_mv", mv(i == 1 ? 8'h0c : i == 2 ? 8'h20 : 8'h3f), 32'(ab_mv));
         check("c_mv", mv(i == 1 ? 8'h3e : i == 2 ? 8'h00 : 8'h01), 32'(c_mv));
         check("ab_en", 32'(i != 2), 32'(ab_en));
         check("c_en", 32'h1, 32'(c_en));
      end
      check("ab_mode", 32'h5, 32'(ab_md));
      check("c_mode", 32'h9, 32'(c_md));
      bus_wr(8'h90, 8'hb5, 2'h0);
      bus_wr(8'hc8, 8'h4e, 2'h0);
      dual <= 1'b1;
      settle();
      check("ab_cfg", 32'h76, {25'h0, ab_il, ab_ph, na_f, na_s});
      check("node_b", 32'h16, {27'h0, nb_en, nb_f, nb_s});
      check("c_cfg", 32'h0d, {25'h0, c_il, c_ph, c_f, c_s});
      @(posedge clk);
      dual <= 1'b0;
      pwr <= 2'h2;
      bus_wr(8'hc4, 8'h09, 2'h0);
      settle();
      check("node_b_off", 32'h0, {27'h0, nb_en, nb_f, nb_s});
      check("c_sleep_en", 32'h0, 32'(c_en));
      tally_and_finish();
   end
endmodule
